// *** design/lkst_pkg.sv ***
// Constants and types for the lock-in status event registers.
// Assumes one 50 MHz clock and a command parser on that same clock.
package lkst_pkg;
	// ----------------------------------------
	// Register widths
	// ----------------------------------------
	localparam int SE_W = 8;
	localparam int LIA_W = 15;
	localparam int ERR_W = 8;
	localparam int SP_W = 8;
	localparam int DW = 16;
	localparam int IW = 4;
	localparam int SELW = 3;

	// ----------------------------------------
	// Standard event bit positions
	// ----------------------------------------
	localparam int SE_DONE = 0;
	localparam int SE_INOVF = 1;
	localparam int SE_OUTOVF = 3;
	localparam int SE_FAIL = 4;
	localparam int SE_CMD = 5;
	localparam int SE_USER = 6;
	localparam int SE_POWER = 7;

	// ----------------------------------------
	// Lock-in condition bit positions
	// ----------------------------------------
	localparam int LI_CH1 = 0;
	localparam int LI_CH2 = 1;
	localparam int LI_UNUSED = 2;
	localparam int LI_UNLOCK = 3;
	localparam int LI_RANGE = 4;
	localparam int LI_SFREQ = 5;
	localparam int LI_SOVL = 6;
	localparam int LI_STORE = 7;
	localparam int LI_DAT1 = 8;
	localparam int LI_DAT2 = 9;
	localparam int LI_DAT3 = 10;
	localparam int LI_DAT4 = 11;
	localparam int LI_CAP = 12;
	localparam int LI_SCST = 13;
	localparam int LI_SCFN = 14;

	// ----------------------------------------
	// Fault bit positions
	// ----------------------------------------
	localparam int ER_CLK = 0;
	localparam int ER_BAT = 1;
	localparam int ER_UN2 = 2;
	localparam int ER_UN3 = 3;
	localparam int ER_NET = 4;
	localparam int ER_FTA = 5;
	localparam int ER_USBD = 6;
	localparam int ER_USBH = 7;

	// ----------------------------------------
	// Serial poll bit positions
	// ----------------------------------------
	localparam int SP_ERR = 2;
	localparam int SP_LIA = 3;
	localparam int SP_MAV = 4;
	localparam int SP_EVT = 5;
	localparam int SP_SRQ = 6;

	// ----------------------------------------
	// Read and write selectors
	// ----------------------------------------
	typedef enum logic [SELW-1:0] {
		LKST_SEL_SE = 3'h0,
		LKST_SEL_LIA = 3'h1,
		LKST_SEL_ERR = 3'h2,
		LKST_SEL_SE_EN = 3'h3,
		LKST_SEL_LIA_EN = 3'h4,
		LKST_SEL_ERR_EN = 3'h5,
		LKST_SEL_SRE = 3'h6,
		LKST_SEL_STB = 3'h7
	} lkst_sel_t;

	localparam logic [DW-1:0] ALL_ONES = 16'hFFFF;
	localparam logic [DW-1:0] ONE_BIT = 16'h0001;

	// ----------------------------------------
	// State of the top module
	// ----------------------------------------
	typedef struct packed {
		logic [SE_W-1:0] se_en;
		logic [LIA_W-1:0] lia_en;
		logic [ERR_W-1:0] err_en;
		logic [SP_W-1:0] sre;
		logic rd_valid;
		logic [DW-1:0] rd_data;
		logic flush;
		logic booted;
	} lkst_main_t;

	localparam lkst_main_t MAIN_RST = '0;
endpackage : lkst_pkg

// *** design/lkst_sticky.sv ***
// Sticky flag register: set pulses latch, clear mask drops bits.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module lkst_sticky import lkst_pkg::*; #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Set and clear
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	// Flags
	output logic [W-1:0] flags
);
	typedef struct packed {
		logic [W-1:0] f;
	} lkst_stk_t;

	lkst_stk_t s;
	lkst_stk_t next_s;

	// ----------------------------------------
	// Latch with set over clear
	// ----------------------------------------
	always_comb begin
		next_s.f = (s.f & ~clr) | set; // [R24] [R7] [R15] [R19]
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign flags = s.f;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_set_wins;
		set != '0 |=> (flags & $past(set)) == $past(set);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set pulse lost"); // [R24]

	property p_hold;
		clr == '0 |=> (flags & $past(flags)) == $past(flags);
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped without clear"); // [R7]
endmodule : lkst_sticky

// *** design/lkst_srq.sv ***
// Service request generator on rising enabled serial poll bits.
// Assumes the poll pulse comes from logic on the same clock.
`timescale 1ns/1ps
module lkst_srq import lkst_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Status and mask
	input wire logic [SP_W-1:0] sum,
	input wire logic [SP_W-1:0] en,
	input wire logic poll,
	// Request
	output logic pending
);
	typedef struct packed {
		logic [SP_W-1:0] prev;
		logic pend;
	} lkst_srq_t;

	lkst_srq_t s;
	lkst_srq_t next_s;
	logic [SP_W-1:0] act;
	logic rise;

	// ----------------------------------------
	// Edge detect and latch
	// ----------------------------------------
	always_comb begin
		act = sum & en;
		act[SP_SRQ] = 1'b0;
		rise = |(act & ~s.prev); // [R22]
		next_s.prev = act;
		next_s.pend = rise | (s.pend & ~poll); // [R22] [R24]
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pending = s.pend;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_steady;
		(act & ~s.prev) == '0;
	endsequence

	property p_single_req;
		pending && poll ##0 s_steady |=> !pending;
	endproperty
	a_single_req: assert property (p_single_req) else $error("repeat request"); // [R22]

	property p_rise_req;
		(act & ~s.prev) != '0 |=> pending;
	endproperty
	a_rise_req: assert property (p_rise_req) else $error("rise missed"); // [R22]
endmodule : lkst_srq

// *** design/lkst_regs.sv ***
// Lock-in status event registers: sticky flags, masks, serial poll.
// Assumes events and commands are one-cycle pulses on the same clock.
//
// Overview of operation
// R1: Operation-complete command sets the operation-complete flag.
// R2: Input queue overflow sets its flag and flushes both queues.
// R3: Output queue overflow sets its flag and flushes both queues.
// R4: Failed command or out-of-range parameter sets execution-error flag.
// R5: Unrecognised command sets the illegal-command flag.
// R6: Front-panel action sets user request; power-up sets power-on flag.
// R7: Standard event flags stay set until read or clear-status.
// R8: Bits 0 and 1 flag output overloads; bit 2 unused.
// R9: Bit 3 flags loss of reference lock.
// R10: Bit 4 flags input range overload.
// R11: Bit 5 sync frequency out of range, bit 6 sync overload.
// R12: Bit 7 flags storage trigger.
// R13: Bits 8 to 11 flag data channel overloads.
// R14: Bit 12 capture done, 13 scan start, 14 scan complete.
// R15: Condition word bits stay set until read or clear-status.
// R16: Fault bit 0 clock input, bit 1 battery; bits 2, 3 unused.
// R17: Fault bit 4 network error, bit 5 fast transfer abort.
// R18: Fault bit 6 USB device error, bit 7 USB host error.
// R19: Fault bits stay set until read or clear-status.
// R20: Whole read clears register; single-bit read clears that bit.
// R21: Summary bit high while any flag and its mask bit both set.
// R22: Service request only on rising enabled poll bit, once.
// R23: Standard event positions 0,1,3,4,5,6,7 as listed; bit 2 unused.
// R24: Set pulses beat a simultaneous clear; nothing lost.
`timescale 1ns/1ps
module lkst_regs import lkst_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Command interface events
	input wire logic op_complete_cmd,
	input wire logic cls_cmd,
	input wire logic input_overflow_flag,
	input wire logic output_overflow_flag,
	input wire logic execution_error_flag,
	input wire logic illegal_cmd_flag,
	input wire logic user_request_flag,
	input wire logic mav,
	// Lock-in events
	input wire logic chan_one_output_overload,
	input wire logic chan_two_output_overload,
	input wire logic reference_unlock_flag,
	input wire logic input_range_overload,
	input wire logic sync_freq_out_of_range,
	input wire logic sync_filter_overload,
	input wire logic storage_triggered_flag,
	input wire logic data_chan_one_overload,
	input wire logic data_chan_two_overload,
	input wire logic data_chan_three_overload,
	input wire logic data_chan_four_overload,
	input wire logic capture_done_flag,
	input wire logic scan_started_flag,
	input wire logic scan_completed_flag,
	// Fault events
	input wire logic ext_clock_fault,
	input wire logic battery_backup_fault,
	input wire logic network_instrument_fault,
	input wire logic fast_transfer_abort,
	input wire logic usb_device_port_fault,
	input wire logic usb_host_port_fault,
	// Register read
	input wire logic rd_req,
	input wire logic [SELW-1:0] rd_sel,
	input wire logic rd_single,
	input wire logic [IW-1:0] rd_bit,
	output logic rd_valid,
	output logic [DW-1:0] rd_data,
	// Register write
	input wire logic wr_req,
	input wire logic [SELW-1:0] wr_sel,
	input wire logic wr_single,
	input wire logic [IW-1:0] wr_bit,
	input wire logic [DW-1:0] wr_value,
	// Serial poll, service request, event summary and queue flush
	input wire logic spoll_req,
	output logic srq,
	output logic event_summary_bit,
	output logic queue_flush
);
	lkst_main_t s;
	lkst_main_t next_s;
	logic [SE_W-1:0] se_set, se_clr, se_flags;
	logic [LIA_W-1:0] lia_set, lia_clr, lia_flags;
	logic [ERR_W-1:0] err_set, err_clr, err_flags;
	logic [SP_W-1:0] sp_sum;
	logic rd_take;
	logic [DW-1:0] word;
	logic srq_pend;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [DW-1:0] bit_mask(input logic [IW-1:0] idx);
		bit_mask = ONE_BIT << idx;
	endfunction : bit_mask

	function automatic logic [DW-1:0] rd_clear(input logic take, input logic hit,
		input logic single, input logic [IW-1:0] idx);
		if (take && hit) begin
			rd_clear = single ? bit_mask(idx) : ALL_ONES; // [R20]
		end else begin
			rd_clear = '0;
		end
	endfunction : rd_clear

	function automatic logic [DW-1:0] wr_apply(input logic [DW-1:0] cur, input logic hit,
		input logic single, input logic [IW-1:0] idx, input logic [DW-1:0] val);
		wr_apply = cur;
		if (hit) begin
			if (single) begin
				wr_apply[idx] = val[0];
			end else begin
				wr_apply = val;
			end
		end
	endfunction : wr_apply

	// ----------------------------------------
	// Event packing
	// ----------------------------------------
	always_comb begin
		se_set = '0;
		se_set[SE_DONE] = op_complete_cmd; // [R1] [R23]
		se_set[SE_INOVF] = input_overflow_flag; // [R2]
		se_set[SE_OUTOVF] = output_overflow_flag; // [R3]
		se_set[SE_FAIL] = execution_error_flag; // [R4]
		se_set[SE_CMD] = illegal_cmd_flag; // [R5]
		se_set[SE_USER] = user_request_flag; // [R6]
		se_set[SE_POWER] = ~s.booted; // [R6]
		lia_set = '0;
		lia_set[LI_CH1] = chan_one_output_overload; // [R8]
		lia_set[LI_CH2] = chan_two_output_overload; // [R8]
		lia_set[LI_UNLOCK] = reference_unlock_flag; // [R9]
		lia_set[LI_RANGE] = input_range_overload; // [R10]
		lia_set[LI_SFREQ] = sync_freq_out_of_range; // [R11]
		lia_set[LI_SOVL] = sync_filter_overload; // [R11]
		lia_set[LI_STORE] = storage_triggered_flag; // [R12]
		lia_set[LI_DAT1] = data_chan_one_overload; // [R13]
		lia_set[LI_DAT2] = data_chan_two_overload; // [R13]
		lia_set[LI_DAT3] = data_chan_three_overload; // [R13]
		lia_set[LI_DAT4] = data_chan_four_overload; // [R13]
		lia_set[LI_CAP] = capture_done_flag; // [R14]
		lia_set[LI_SCST] = scan_started_flag; // [R14]
		lia_set[LI_SCFN] = scan_completed_flag; // [R14]
		err_set = '0;
		err_set[ER_CLK] = ext_clock_fault; // [R16]
		err_set[ER_BAT] = battery_backup_fault; // [R16]
		err_set[ER_NET] = network_instrument_fault; // [R17]
		err_set[ER_FTA] = fast_transfer_abort; // [R17]
		err_set[ER_USBD] = usb_device_port_fault; // [R18]
		err_set[ER_USBH] = usb_host_port_fault; // [R18]
	end

	// ----------------------------------------
	// Clear masks
	// ----------------------------------------
	assign rd_take = rd_req & ~spoll_req;

	always_comb begin
		se_clr = SE_W'(rd_clear(rd_take, rd_sel == LKST_SEL_SE, rd_single, rd_bit));
		lia_clr = LIA_W'(rd_clear(rd_take, rd_sel == LKST_SEL_LIA, rd_single, rd_bit));
		err_clr = ERR_W'(rd_clear(rd_take, rd_sel == LKST_SEL_ERR, rd_single, rd_bit));
		if (cls_cmd) begin
			se_clr = '1; // [R7]
			lia_clr = '1; // [R15]
			err_clr = '1; // [R19]
		end
	end

	// ----------------------------------------
	// Flag registers
	// ----------------------------------------
	lkst_sticky #(.W(SE_W)) u_se (
		.clk(clk),
		.rstn(rstn),
		.set(se_set),
		.clr(se_clr),
		.flags(se_flags)
	);

	lkst_sticky #(.W(LIA_W)) u_lia (
		.clk(clk),
		.rstn(rstn),
		.set(lia_set),
		.clr(lia_clr),
		.flags(lia_flags)
	);

	lkst_sticky #(.W(ERR_W)) u_err (
		.clk(clk),
		.rstn(rstn),
		.set(err_set),
		.clr(err_clr),
		.flags(err_flags)
	);

	// ----------------------------------------
	// Serial poll summary
	// ----------------------------------------
	always_comb begin
		sp_sum = '0;
		sp_sum[SP_ERR] = |(err_flags & s.err_en); // [R21]
		sp_sum[SP_LIA] = |(lia_flags & s.lia_en); // [R21]
		sp_sum[SP_MAV] = mav;
		sp_sum[SP_EVT] = |(se_flags & s.se_en); // [R21]
	end

	lkst_srq u_srq (
		.clk(clk),
		.rstn(rstn),
		.sum(sp_sum),
		.en(s.sre),
		.poll(spoll_req),
		.pending(srq_pend)
	);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		case (lkst_sel_t'(rd_sel))
			LKST_SEL_SE: word = DW'(se_flags);
			LKST_SEL_LIA: word = DW'(lia_flags);
			LKST_SEL_ERR: word = DW'(err_flags);
			LKST_SEL_SE_EN: word = DW'(s.se_en);
			LKST_SEL_LIA_EN: word = DW'(s.lia_en);
			LKST_SEL_ERR_EN: word = DW'(s.err_en);
			LKST_SEL_SRE: word = DW'(s.sre);
			LKST_SEL_STB: begin
				word = DW'(sp_sum);
				word[SP_SRQ] = |(sp_sum & s.sre);
			end
			default: word = '0;
		endcase
		if (rd_single) begin
			word = DW'(word[rd_bit]);
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.booted = 1'b1;
		next_s.flush = input_overflow_flag | output_overflow_flag; // [R2] [R3]
		next_s.rd_valid = rd_req | spoll_req;
		if (spoll_req) begin
			next_s.rd_data = DW'(sp_sum);
			next_s.rd_data[SP_SRQ] = srq_pend;
		end else if (rd_req) begin
			next_s.rd_data = word;
		end
		if (wr_req) begin
			next_s.se_en = SE_W'(wr_apply(DW'(s.se_en), wr_sel == LKST_SEL_SE_EN,
				wr_single, wr_bit, wr_value));
			next_s.lia_en = LIA_W'(wr_apply(DW'(s.lia_en), wr_sel == LKST_SEL_LIA_EN,
				wr_single, wr_bit, wr_value));
			next_s.err_en = ERR_W'(wr_apply(DW'(s.err_en), wr_sel == LKST_SEL_ERR_EN,
				wr_single, wr_bit, wr_value));
			next_s.sre = SP_W'(wr_apply(DW'(s.sre), wr_sel == LKST_SEL_SRE,
				wr_single, wr_bit, wr_value));
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= MAIN_RST;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rd_valid = s.rd_valid;
	assign rd_data = s.rd_data;
	assign queue_flush = s.flush;
	assign srq = srq_pend;
	assign event_summary_bit = sp_sum[SP_EVT];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_op_done;
		op_complete_cmd |=> se_flags[SE_DONE];
	endproperty
	a_op_done: assert property (p_op_done) else $error("completion flag not set"); // [R1]

	sequence s_overflow;
		input_overflow_flag || output_overflow_flag;
	endsequence

	property p_flush;
		s_overflow |=> queue_flush ##1 queue_flush == $past(input_overflow_flag | output_overflow_flag);
	endproperty
	a_flush: assert property (p_flush) else $error("queue flush wrong"); // [R2] [R3]

	property p_se_events;
		execution_error_flag || illegal_cmd_flag || user_request_flag |=> &(se_flags[SE_USER:SE_FAIL]
			| ~$past({user_request_flag, illegal_cmd_flag, execution_error_flag}));
	endproperty
	a_se_events: assert property (p_se_events) else $error("event flag lost"); // [R4] [R5] [R6]

	property p_pon;
		!s.booted |=> se_flags[SE_POWER];
	endproperty
	a_pon: assert property (p_pon) else $error("power-on flag missing"); // [R6]

	property p_lia_set;
		lia_set != '0 |=> (lia_flags & $past(lia_set)) == $past(lia_set);
	endproperty
	a_lia_set: assert property (p_lia_set) else $error("lock-in flag lost"); // [R9] [R13]

	property p_unused;
		!lia_flags[LI_UNUSED] && !err_flags[ER_UN2] && !err_flags[ER_UN3];
	endproperty
	a_unused: assert property (p_unused) else $error("unused bit set"); // [R8] [R16]

	property p_err_set;
		err_set != '0 |=> (err_flags & $past(err_set)) == $past(err_set);
	endproperty
	a_err_set: assert property (p_err_set) else $error("fault flag lost"); // [R17] [R18]

	property p_whole_clear;
		rd_take && !rd_single && rd_sel == LKST_SEL_LIA && lia_set == '0 |=> lia_flags == '0;
	endproperty
	a_whole_clear: assert property (p_whole_clear) else $error("read did not clear"); // [R20]

	property p_cls;
		cls_cmd && err_set == '0 |=> err_flags == '0;
	endproperty
	a_cls: assert property (p_cls) else $error("clear-status missed"); // [R19]

	property p_summary;
		event_summary_bit == |(se_flags & s.se_en);
	endproperty
	a_summary: assert property (p_summary) else $error("summary wrong"); // [R21]
endmodule : lkst_regs

// *** dv/lkst_host.sv ***
// Host model: issues register reads, writes and serial polls.
// Assumes the device samples requests on the rising edge of clk.
`timescale 1ns/1ps
module lkst_host import lkst_pkg::*; (
	// Clock
	input wire logic clk,
	// Read and poll
	output logic rd_req,
	output logic [SELW-1:0] rd_sel,
	output logic rd_single,
	output logic [IW-1:0] rd_bit,
	output logic spoll_req,
	input wire logic rd_valid,
	input wire logic [DW-1:0] rd_data,
	// Write
	output logic wr_req,
	output logic [SELW-1:0] wr_sel,
	output logic wr_single,
	output logic [IW-1:0] wr_bit,
	output logic [DW-1:0] wr_value
);
	initial begin
		{rd_req, rd_sel, rd_single, rd_bit, spoll_req} = '0;
		{wr_req, wr_sel, wr_single, wr_bit, wr_value} = '0;
	end

	// ----------------------------------------
	// Read or poll, answer one cycle later
	// ----------------------------------------
	task automatic xfer(input logic poll, input logic [SELW-1:0] sel, input logic single,
		input logic [IW-1:0] idx, output logic ok, output logic [DW-1:0] data);
		@(posedge clk);
		#1;
		{rd_sel, rd_single, rd_bit} = {sel, single, idx};
		if (poll) begin
			spoll_req = 1'b1;
		end else begin
			rd_req = 1'b1;
		end
		@(posedge clk);
		#1;
		rd_req = 1'b0;
		spoll_req = 1'b0;
		ok = rd_valid;
		data = rd_data;
	endtask : xfer

	// ----------------------------------------
	// Mask write
	// ----------------------------------------
	task automatic wr_reg(input logic [SELW-1:0] sel, input logic single,
		input logic [IW-1:0] idx, input logic [DW-1:0] val);
		@(posedge clk);
		#1;
		{wr_req, wr_sel, wr_single, wr_bit, wr_value} = {1'b1, sel, single, idx, val};
		@(posedge clk);
		#1;
		wr_req = 1'b0;
	endtask : wr_reg
endmodule : lkst_host

// *** dv/lkst_regs_test.sv ***
// Testbench for the lock-in status event registers.
// Assumes the host model drives reads and writes; events come from here.
`timescale 1ns/1ps
module lkst_regs_test import lkst_pkg::*;;
	typedef struct packed {
		logic [SELW-1:0] sel;
		logic [IW-1:0] pos;
		logic fl;
	} lkst_row_t;

	logic clk;
	logic rstn;
	logic mav;
	logic [26:0] ev;
	logic rd_req, rd_single, rd_valid, spoll_req, wr_req, wr_single;
	logic [SELW-1:0] rd_sel, wr_sel;
	logic [IW-1:0] rd_bit, wr_bit;
	logic [DW-1:0] rd_data, wr_value;
	logic srq, event_summary_bit, queue_flush;
	int num_errors = 0;
	int checks = 0;
	lkst_row_t rows [26] = '{
		'{LKST_SEL_SE, SE_DONE, 0}, '{LKST_SEL_SE, SE_INOVF, 1}, '{LKST_SEL_SE, SE_OUTOVF, 1},
		'{LKST_SEL_SE, SE_FAIL, 0}, '{LKST_SEL_SE, SE_CMD, 0}, '{LKST_SEL_SE, SE_USER, 0},
		'{LKST_SEL_LIA, LI_CH1, 0}, '{LKST_SEL_LIA, LI_CH2, 0}, '{LKST_SEL_LIA, LI_UNLOCK, 0},
		'{LKST_SEL_LIA, LI_RANGE, 0}, '{LKST_SEL_LIA, LI_SFREQ, 0}, '{LKST_SEL_LIA, LI_SOVL, 0},
		'{LKST_SEL_LIA, LI_STORE, 0}, '{LKST_SEL_LIA, LI_DAT1, 0}, '{LKST_SEL_LIA, LI_DAT2, 0},
		'{LKST_SEL_LIA, LI_DAT3, 0}, '{LKST_SEL_LIA, LI_DAT4, 0}, '{LKST_SEL_LIA, LI_CAP, 0},
		'{LKST_SEL_LIA, LI_SCST, 0}, '{LKST_SEL_LIA, LI_SCFN, 0}, '{LKST_SEL_ERR, ER_CLK, 0},
		'{LKST_SEL_ERR, ER_BAT, 0}, '{LKST_SEL_ERR, ER_NET, 0}, '{LKST_SEL_ERR, ER_FTA, 0},
		'{LKST_SEL_ERR, ER_USBD, 0}, '{LKST_SEL_ERR, ER_USBH, 0}};

	lkst_regs i_lkst_regs (.clk(clk), .rstn(rstn), .op_complete_cmd(ev[0]), .cls_cmd(ev[26]),
		.input_overflow_flag(ev[1]), .output_overflow_flag(ev[2]),
		.execution_error_flag(ev[3]), .illegal_cmd_flag(ev[4]), .user_request_flag(ev[5]),
		.mav(mav), .chan_one_output_overload(ev[6]), .chan_two_output_overload(ev[7]),
		.reference_unlock_flag(ev[8]), .input_range_overload(ev[9]),
		.sync_freq_out_of_range(ev[10]), .sync_filter_overload(ev[11]),
		.storage_triggered_flag(ev[12]), .data_chan_one_overload(ev[13]),
		.data_chan_two_overload(ev[14]), .data_chan_three_overload(ev[15]),
		.data_chan_four_overload(ev[16]), .capture_done_flag(ev[17]),
		.scan_started_flag(ev[18]), .scan_completed_flag(ev[19]), .ext_clock_fault(ev[20]),
		.battery_backup_fault(ev[21]), .network_instrument_fault(ev[22]),
		.fast_transfer_abort(ev[23]), .usb_device_port_fault(ev[24]),
		.usb_host_port_fault(ev[25]), .rd_req(rd_req), .rd_sel(rd_sel),
		.rd_single(rd_single), .rd_bit(rd_bit), .rd_valid(rd_valid), .rd_data(rd_data),
		.wr_req(wr_req), .wr_sel(wr_sel), .wr_single(wr_single), .wr_bit(wr_bit),
		.wr_value(wr_value), .spoll_req(spoll_req), .srq(srq),
		.event_summary_bit(event_summary_bit), .queue_flush(queue_flush));

	lkst_host i_lkst_host (.clk(clk), .rd_req(rd_req), .rd_sel(rd_sel), .rd_single(rd_single),
		.rd_bit(rd_bit), .spoll_req(spoll_req), .rd_valid(rd_valid), .rd_data(rd_data),
		.wr_req(wr_req), .wr_sel(wr_sel), .wr_single(wr_single), .wr_bit(wr_bit),
		.wr_value(wr_value));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [DW:0] got, input logic [DW:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic poll, input logic [SELW-1:0] sel, input logic single,
		input logic [IW-1:0] idx, input logic [DW-1:0] exp);
		logic ok;
		logic [DW-1:0] d;
		i_lkst_host.xfer(poll, sel, single, idx, ok, d);
		chk({ok, d}, {1'b1, exp});
	endtask : rd

	task automatic pulse(input logic [26:0] m);
		@(posedge clk);
		#1;
		ev = m;
		@(posedge clk);
		#1;
		ev = '0;
	endtask : pulse

	task automatic bit_is(input logic b, input logic exp);
		chk({16'h0000, b}, {16'h0000, exp});
	endtask : bit_is

	task automatic wrap_up();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// Clock, reset, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		wrap_up();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		mav = 1'b0;
		ev = '0;
		repeat (6) @(posedge clk);
		#1;
		rstn = 1'b1;
		pulse(27'h400_0000);
		for (int i = 0; i < 26; i++) begin
			pulse(27'(1) << i);
			bit_is(queue_flush, rows[i].fl);
			rd(1'b0, rows[i].sel, 1'b0, 4'h0, ONE_BIT << rows[i].pos);
			rd(1'b0, rows[i].sel, 1'b0, 4'h0, 16'h0000);
		end
		// Latch, single-bit clear, clear-status
		pulse(27'h040_1008);
		repeat (4) @(posedge clk);
		rd(1'b0, LKST_SEL_SE, 1'b1, 4'h4, 16'h0001);
		rd(1'b0, LKST_SEL_SE, 1'b0, 4'h0, 16'h0000);
		pulse(27'h400_0000);
		rd(1'b0, LKST_SEL_LIA, 1'b0, 4'h0, 16'h0000);
		rd(1'b0, LKST_SEL_ERR, 1'b0, 4'h0, 16'h0000);
		pulse(27'h000_2100);
		rd(1'b0, LKST_SEL_LIA, 1'b1, 4'h3, 16'h0001);
		rd(1'b0, LKST_SEL_LIA, 1'b0, 4'h0, 16'h0100);
		// Set against simultaneous clear
		fork
			pulse(27'h000_0100);
			rd(1'b0, LKST_SEL_LIA, 1'b0, 4'h0, 16'h0000);
		join
		pulse(27'h400_0100);
		rd(1'b0, LKST_SEL_LIA, 1'b0, 4'h0, 16'h0008);
		// Summary bits and service request
		i_lkst_host.wr_reg(LKST_SEL_LIA_EN, 1'b0, 4'h0, 16'h0008);
		i_lkst_host.wr_reg(LKST_SEL_SRE, 1'b0, 4'h0, 16'h0008);
		i_lkst_host.wr_reg(LKST_SEL_STB, 1'b0, 4'h0, 16'hFFFF);
		rd(1'b0, LKST_SEL_SRE, 1'b0, 4'h0, 16'h0008);
		pulse(27'h000_0100);
		@(posedge clk);
		#1;
		bit_is(srq, 1'b1);
		rd(1'b1, LKST_SEL_STB, 1'b0, 4'h0, 16'h0048);
		bit_is(srq, 1'b0);
		pulse(27'h000_0100);
		repeat (2) @(posedge clk);
		#1;
		bit_is(srq, 1'b0);
		rd(1'b0, LKST_SEL_LIA, 1'b0, 4'h0, 16'h0008);
		pulse(27'h000_0100);
		@(posedge clk);
		#1;
		bit_is(srq, 1'b1);
		i_lkst_host.wr_reg(LKST_SEL_SE_EN, 1'b1, 4'h4, 16'h0001);
		pulse(27'h000_0008);
		bit_is(event_summary_bit, 1'b1);
		rd(1'b0, LKST_SEL_SE, 1'b0, 4'h0, 16'h0010);
		bit_is(event_summary_bit, 1'b0);
		pulse(27'h000_0010);
		bit_is(event_summary_bit, 1'b0);
		// Fault summary, mask readback, status byte read
		mav = 1'b1;
		i_lkst_host.wr_reg(LKST_SEL_ERR_EN, 1'b0, 4'h0, 16'h0020);
		rd(1'b0, LKST_SEL_ERR_EN, 1'b0, 4'h0, 16'h0020);
		pulse(27'h080_0000);
		rd(1'b0, LKST_SEL_STB, 1'b0, 4'h0, 16'h005C);
		rd(1'b0, LKST_SEL_ERR, 1'b1, 4'h5, 16'h0001);
		rd(1'b0, LKST_SEL_STB, 1'b0, 4'h0, 16'h0058);
		// Second reset
		@(posedge clk);
		#1;
		rstn = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rstn = 1'b1;
		bit_is(srq, 1'b0);
		rd(1'b0, LKST_SEL_SE, 1'b0, 4'h0, 16'h0080);
		rd(1'b0, LKST_SEL_SRE, 1'b0, 4'h0, 16'h0000);
		rd(1'b0, LKST_SEL_LIA, 1'b0, 4'h0, 16'h0000);
		wrap_up();
	end
endmodule : lkst_regs_test
